//--- core/port_e_pin_function_select.v
`timescale 1ns/1ps
`include "port_e_pfc_regs.vh"

module port_e_pin_function_select (
  input wire mclk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PFC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  // port E pins
  input wire [15:0] peIn,
  output reg [15:0] peOut,
  output reg [15:0] peOe,
  input wire [15:0] peDataLatch,
  // port A low pins
  output wire [15:0] paDataLow,
  // timer capture/compare: index 0..7 = 0A,0B,0C,0D,1A,1B,2A,2B
  input wire [7:0] timerCcOut,
  input wire [7:0] timerCcOe,
  output reg [7:0] timerCcIn,
  // DMA and bus signals
  input wire dmaAckCh0,
  input wire dmaAckCh1,
  input wire addressHoldOut,
  input wire dmaReqAcceptedCh0,
  input wire dmaReqAcceptedCh1,
  output reg dmaRequestCh1
);

  reg [15:0] portADataLow_reg;
  reg [15:0] portEDirection_reg;
  reg [15:0] portEFunctionHigh_reg;
  reg [15:0] portEFunctionLow_reg;
  reg [31:0] rdata_reg;
  reg slverr_reg;
  reg [15:0] readValue;
  reg hit;
  reg [1:0] func15;
  reg [1:0] func14;
  reg [1:0] func3;
  reg [1:0] func2;
  reg [1:0] func1;
  reg [1:0] func0;
  integer i;

  wire setupPhase;
  wire accessPhase;
  wire doWrite;
  wire selADataLow;
  wire selEDirection;
  wire selEFunctionHigh;
  wire selEFunctionLow;

  // byte address of a printed index, kept to the decoded width
  function [`PFC_ADDR_W-1:0] idxToAddr;
    input [31:0] idx;
    reg [31:0] scaled;
    begin
      scaled = idx << 2;
      idxToAddr = scaled[`PFC_ADDR_W-1:0];
    end
  endfunction

  // lane-masked write: only strobed bytes and writable bits change
  function [15:0] laneMerge;
    input [15:0] oldVal;
    input [31:0] wdata;
    input [3:0] strb;
    input [15:0] wmask;
    reg [15:0] laneMask;
    begin
      laneMask = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      laneMerge = (oldVal & ~laneMask) | (wdata[15:0] & laneMask);
    end
  endfunction

  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  // zero wait states: read data is captured in setup, answered in access
  assign pready = accessPhase;
  assign prdata = rdata_reg;
  assign pslverr = accessPhase & slverr_reg;
  assign doWrite = accessPhase & pwrite & ~slverr_reg;

  assign selADataLow = (paddr == idxToAddr(`IDX_PORT_A_DATA_LOW));
  assign selEDirection = (paddr == idxToAddr(`IDX_PORT_E_DIRECTION));
  assign selEFunctionHigh = (paddr == idxToAddr(`IDX_PORT_E_FUNCTION_HIGH));
  assign selEFunctionLow = (paddr == idxToAddr(`IDX_PORT_E_FUNCTION_LOW));

  always @*
  begin
    hit = 1'b1;
    if (selADataLow)
    begin
      readValue = portADataLow_reg;
    end
    else if (selEDirection)
    begin
      readValue = portEDirection_reg;
    end
    else if (selEFunctionHigh)
    begin
      readValue = portEFunctionHigh_reg & `WMASK_PORT_E_FUNCTION_HIGH;
    end
    else if (selEFunctionLow)
    begin
      readValue = portEFunctionLow_reg & `WMASK_PORT_E_FUNCTION_LOW;
    end
    else
    begin
      readValue = 16'h0000;
      hit = 1'b0;
    end
  end

  // read data and error flag latched in the setup cycle
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end
    else if (setupPhase)
    begin
      rdata_reg <= {16'h0000, readValue};
      slverr_reg <= ~hit;
    end
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      portADataLow_reg <= `RST_PORT_A_DATA_LOW;
      portEDirection_reg <= `RST_PORT_E_DIRECTION;
      portEFunctionHigh_reg <= `RST_PORT_E_FUNCTION_HIGH;
      portEFunctionLow_reg <= `RST_PORT_E_FUNCTION_LOW;
    end
    else if (doWrite)
    begin
      if (selADataLow)
      begin
        portADataLow_reg <= laneMerge(portADataLow_reg, pwdata, pstrb,
          `WMASK_PORT_A_DATA_LOW);
      end
      else if (selEDirection)
      begin
        portEDirection_reg <= laneMerge(portEDirection_reg, pwdata, pstrb,
          `WMASK_PORT_E_DIRECTION);
      end
      else if (selEFunctionHigh)
      begin
        portEFunctionHigh_reg <= laneMerge(portEFunctionHigh_reg, pwdata, pstrb,
          `WMASK_PORT_E_FUNCTION_HIGH);
      end
      else if (selEFunctionLow)
      begin
        portEFunctionLow_reg <= laneMerge(portEFunctionLow_reg, pwdata, pstrb,
          `WMASK_PORT_E_FUNCTION_LOW);
      end
    end
  end

  assign paDataLow = portADataLow_reg;

  // pin multiplexer
  always @*
  begin
    func15 = portEFunctionHigh_reg[`FLD_PIN15_FUNC_LO+1:`FLD_PIN15_FUNC_LO];
    func14 = portEFunctionHigh_reg[`FLD_PIN14_FUNC_LO+1:`FLD_PIN14_FUNC_LO];
    func3 = portEFunctionLow_reg[`FLD_PIN3_FUNC_LO+1:`FLD_PIN3_FUNC_LO];
    func2 = portEFunctionLow_reg[`FLD_PIN2_FUNC_LO+1:`FLD_PIN2_FUNC_LO];
    func1 = portEFunctionLow_reg[`FLD_PIN1_FUNC_LO+1:`FLD_PIN1_FUNC_LO];
    func0 = portEFunctionLow_reg[`FLD_PIN0_FUNC_LO+1:`FLD_PIN0_FUNC_LO];
    // default: every pin in plain I/O
    for (i = 0; i < 16; i = i + 1)
    begin
      peOut[i] = portEDirection_reg[i] & peDataLatch[i];
      peOe[i] = portEDirection_reg[i];
    end
    timerCcIn = 8'h00;
    // request idles high so an unrouted pin never raises a request
    dmaRequestCh1 = 1'b1;

    // reserved codes float the pin rather than guess a function
    case (func15)
      `FUNC_PLAIN_IO:
      begin
        peOut[15] = portEDirection_reg[15] & peDataLatch[15];
      end
      `FUNC_DMA:
      begin
        peOut[15] = dmaAckCh1;
        peOe[15] = 1'b1;
      end
      default:
      begin
        peOut[15] = 1'b0;
        peOe[15] = 1'b0;
      end
    endcase

    case (func14)
      `FUNC_PLAIN_IO:
      begin
        peOut[14] = portEDirection_reg[14] & peDataLatch[14];
      end
      `FUNC_DMA:
      begin
        peOut[14] = dmaAckCh0;
        peOe[14] = 1'b1;
      end
      `FUNC_ALT:
      begin
        peOut[14] = addressHoldOut;
        peOe[14] = 1'b1;
      end
      default:
      begin
        peOut[14] = 1'b0;
        peOe[14] = 1'b0;
      end
    endcase

    // pins 7..4 to timer 2B,2A,1B,1A
    if (portEFunctionLow_reg[`FLD_PIN7_FUNC_SEL])
    begin
      peOut[7] = timerCcOut[7];
      peOe[7] = timerCcOe[7];
      timerCcIn[7] = peIn[7];
    end
    if (portEFunctionLow_reg[`FLD_PIN6_FUNC_SEL])
    begin
      peOut[6] = timerCcOut[6];
      peOe[6] = timerCcOe[6];
      timerCcIn[6] = peIn[6];
    end
    if (portEFunctionLow_reg[`FLD_PIN5_FUNC_SEL])
    begin
      peOut[5] = timerCcOut[5];
      peOe[5] = timerCcOe[5];
      timerCcIn[5] = peIn[5];
    end
    if (portEFunctionLow_reg[`FLD_PIN4_FUNC_SEL])
    begin
      peOut[4] = timerCcOut[4];
      peOe[4] = timerCcOe[4];
      timerCcIn[4] = peIn[4];
    end

    case (func3)
      `FUNC_PLAIN_IO:
      begin
        peOut[3] = portEDirection_reg[3] & peDataLatch[3];
      end
      `FUNC_TIMER:
      begin
        peOut[3] = timerCcOut[3];
        peOe[3] = timerCcOe[3];
        timerCcIn[3] = peIn[3];
      end
      `FUNC_DMA:
      begin
        peOut[3] = dmaReqAcceptedCh1;
        peOe[3] = 1'b1;
      end
      default:
      begin
        peOut[3] = 1'b0;
        peOe[3] = 1'b0;
      end
    endcase

    case (func2)
      `FUNC_PLAIN_IO:
      begin
        peOut[2] = portEDirection_reg[2] & peDataLatch[2];
      end
      `FUNC_TIMER:
      begin
        peOut[2] = timerCcOut[2];
        peOe[2] = timerCcOe[2];
        timerCcIn[2] = peIn[2];
      end
      `FUNC_DMA:
      begin
        peOut[2] = 1'b0;
        peOe[2] = 1'b0;
        dmaRequestCh1 = peIn[2];
      end
      default:
      begin
        peOut[2] = 1'b0;
        peOe[2] = 1'b0;
      end
    endcase

    case (func1)
      `FUNC_PLAIN_IO:
      begin
        peOut[1] = portEDirection_reg[1] & peDataLatch[1];
      end
      `FUNC_TIMER:
      begin
        peOut[1] = timerCcOut[1];
        peOe[1] = timerCcOe[1];
        timerCcIn[1] = peIn[1];
      end
      `FUNC_DMA:
      begin
        peOut[1] = dmaReqAcceptedCh0;
        peOe[1] = 1'b1;
      end
      default:
      begin
        peOut[1] = 1'b0;
        peOe[1] = 1'b0;
      end
    endcase

    case (func0)
      `FUNC_PLAIN_IO:
      begin
        peOut[0] = portEDirection_reg[0] & peDataLatch[0];
      end
      `FUNC_TIMER:
      begin
        peOut[0] = timerCcOut[0];
        peOe[0] = timerCcOe[0];
        timerCcIn[0] = peIn[0];
      end
      `FUNC_DMA:
      begin
        peOut[0] = dmaReqAcceptedCh0;
        peOe[0] = 1'b1;
      end
      default:
      begin
        peOut[0] = 1'b0;
        peOe[0] = 1'b0;
      end
    endcase
  end

endmodule // port_e_pin_function_select

//--- core/port_e_pfc_regs.vh
`ifndef PORT_E_PFC_REGS_VH
`define PORT_E_PFC_REGS_VH

// register indices as printed; byte address is four times the index
`define IDX_PORT_A_DATA_LOW 32'hFFFF8382
`define IDX_PORT_E_DIRECTION 32'hFFFF83B4
`define IDX_PORT_E_FUNCTION_HIGH 32'hFFFF83B8
`define IDX_PORT_E_FUNCTION_LOW 32'hFFFF83BA

// decoded address width of the bus slave
`define PFC_ADDR_W 20

// reset values
`define RST_PORT_A_DATA_LOW 16'h0000
`define RST_PORT_E_DIRECTION 16'h0000
`define RST_PORT_E_FUNCTION_HIGH 16'h0000
`define RST_PORT_E_FUNCTION_LOW 16'h0000

// writable bit masks, all other bits read as zero
`define WMASK_PORT_A_DATA_LOW 16'hFFFF
`define WMASK_PORT_E_DIRECTION 16'hFFFF
`define WMASK_PORT_E_FUNCTION_HIGH 16'hF000
`define WMASK_PORT_E_FUNCTION_LOW 16'h55FF

// field positions, function high register
`define FLD_PIN15_FUNC_LO 14
`define FLD_PIN14_FUNC_LO 12
// field positions, function low register
`define FLD_PIN7_FUNC_SEL 14
`define FLD_PIN6_FUNC_SEL 12
`define FLD_PIN5_FUNC_SEL 10
`define FLD_PIN4_FUNC_SEL 8
`define FLD_PIN3_FUNC_LO 6
`define FLD_PIN2_FUNC_LO 4
`define FLD_PIN1_FUNC_LO 2
`define FLD_PIN0_FUNC_LO 0

// two-bit function codes
`define FUNC_PLAIN_IO 2'h0
`define FUNC_TIMER 2'h1
`define FUNC_DMA 2'h2
`define FUNC_ALT 2'h3

`endif

//--- bench/port_e_pin_function_select_monitor.sv
`timescale 1ns/1ps
`include "port_e_pfc_regs.vh"
module port_e_pin_function_select_monitor (
  input wire mclk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PFC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [15:0] peIn,
  input wire [15:0] peOut,
  input wire [15:0] peOe,
  input wire [15:0] peDataLatch,
  input wire [15:0] paDataLow,
  input wire [7:0] timerCcIn,
  input wire dmaRequestCh1
);
  localparam [31:0] PA_BYTE = `IDX_PORT_A_DATA_LOW * 4;
  wire [15:0] wLow = pwdata[15:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_ready_no_wait: assert property (psel && penable |-> pready)
    else $error("pready missing in access");
  chk_upper_zero: assert property (
    pready |-> prdata[31:16] == 16'h0000) else $error("upper read data set");
  chk_err_quiet: assert property (
    pslverr |-> psel && penable && prdata == 32'h00000000) else $error("bad error reply");
  chk_latch_write: assert property (
    psel && penable && pwrite && pstrb[1:0] == 2'h3 && paddr == PA_BYTE[19:0]
    |=> paDataLow == $past(wLow)) else $error("port A latch not written");
  chk_latch_hold: assert property (
    !(psel && penable && pwrite) |=> $stable(paDataLow)) else $error("port A latch moved");
  chk_cc_routed: assert property (
    (timerCcIn & ~peIn[7:0]) == 8'h00) else $error("timer input not from pin");
  chk_dreq_input: assert property (
    !dmaRequestCh1 |-> !peOe[2] && !peIn[2]) else $error("request pin driven");
  chk_plain_mid: assert property (
    peOut[13:8] == (peOe[13:8] & peDataLatch[13:8])) else $error("plain pin wrong");
  chk_reset_idle: assert property (
    $fell(sys_rst) |-> peOe == 16'h0000 && paDataLow == 16'h0000 && dmaRequestCh1)
    else $error("not idle after reset");
endmodule // port_e_pin_function_select_monitor

//--- bench/periph_model.sv
`timescale 1ns/1ps
module periph_model (
  input wire mclk,
  output wire [15:0] peIn,
  output wire [15:0] peDataLatch,
  output wire [7:0] timerCcOut,
  output wire [7:0] timerCcOe,
  output wire [4:0] dmaOut
);
  reg [15:0] lfsr_reg = 16'hB3C5;
  // live levels move every cycle so a stale route cannot match by luck
  always @(posedge mclk)
    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  assign peIn = lfsr_reg;
  assign peDataLatch = {lfsr_reg[7:0], lfsr_reg[15:8]} ^ 16'hA5C3;
  assign timerCcOut = lfsr_reg[11:4];
  assign timerCcOe = lfsr_reg[15:8] ^ lfsr_reg[7:0];
  assign dmaOut = lfsr_reg[14:10] ^ lfsr_reg[4:0];
endmodule // periph_model

//--- bench/port_e_pin_function_select_bench.sv
`timescale 1ns/1ps
`include "port_e_pfc_regs.vh"
module port_e_pin_function_select_bench;
  reg mclk, sys_rst, psel, penable, pwrite, errVal;
  reg [19:0] paddr;
  reg [31:0] pwdata, rdVal;
  reg [3:0] pstrb;
  wire pready, pslverr, dmaRequestCh1;
  wire [31:0] prdata;
  wire [15:0] peIn, peOut, peOe, peDataLatch, paDataLow;
  wire [7:0] timerCcOut, timerCcOe, timerCcIn;
  wire [4:0] dma;
  reg [15:0] rnd, xo, xe;
  reg [7:0] xt;
  reg [19:0] ra [0:3];
  reg [15:0] wm [0:3];
  reg [15:0] sh [0:3];
  reg [1:0] c;
  integer miscompares, n_compared, k, j;

  always #12.5 mclk = ~mclk;

  port_e_pin_function_select u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .peIn(peIn), .peOut(peOut), .peOe(peOe),
    .peDataLatch(peDataLatch), .paDataLow(paDataLow), .timerCcOut(timerCcOut),
    .timerCcOe(timerCcOe), .timerCcIn(timerCcIn), .dmaAckCh0(dma[0]), .dmaAckCh1(dma[1]),
    .addressHoldOut(dma[2]), .dmaReqAcceptedCh0(dma[3]), .dmaReqAcceptedCh1(dma[4]),
    .dmaRequestCh1(dmaRequestCh1)
  );

  periph_model u_far (
    .mclk(mclk), .peIn(peIn), .peDataLatch(peDataLatch), .timerCcOut(timerCcOut),
    .timerCcOe(timerCcOe), .dmaOut(dma)
  );

  function [15:0] nx;
    input dummy;
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    nx = rnd;
  endfunction

  task chk(input string nm, input [32:0] got, input [32:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one idle edge before each setup keeps psel from being assigned twice
  task apb(input w, input [19:0] a, input [15:0] d, input [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no cycle count assumed: only the watchdog ends a stuck access
    while (pready !== 1'b1)
      @(posedge mclk);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task put(input integer p, input en, input v);
    xe[p] = en;
    xo[p] = v;
  endtask

  task check_pins;
    integer i;
    reg [1:0] f;
    xo = sh[1] & peDataLatch;
    xe = sh[1];
    xt = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      f = i < 4 ? sh[3][2*i+:2] : {1'b0, sh[3][2*i]};
      if (f == 2'h1)
      begin
        put(i, timerCcOe[i], timerCcOut[i]);
        xt[i] = peIn[i];
      end
      else if (f == 2'h3 || (f == 2'h2 && i == 2))
        put(i, 1'b0, 1'b0);
      else if (f == 2'h2)
        put(i, 1'b1, i == 3 ? dma[4] : dma[3]);
    end
    f = sh[2][15:14];
    if (f == 2'h2)
      put(15, 1'b1, dma[1]);
    else if (f != 2'h0)
      put(15, 1'b0, 1'b0);
    f = sh[2][13:12];
    if (f[1])
      put(14, 1'b1, f[0] ? dma[2] : dma[0]);
    else if (f[0])
      put(14, 1'b0, 1'b0);
    chk("peOut", peOut, xo);
    chk("peOe", peOe, xe);
    chk("ccIn", timerCcIn, xt);
    chk("dreq", dmaRequestCh1, sh[3][5:4] == 2'h2 ? peIn[2] : 1'b1);
    chk("paLow", paDataLow, sh[0]);
  endtask

  task acc(input w, input [1:0] r, input [15:0] d, input [3:0] s);
    reg [15:0] m;
    apb(w, ra[r], d, s);
    m = {{8{s[1]}}, {8{s[0]}}} & wm[r];
    if (w)
      sh[r] = (sh[r] & ~m) | (d & m);
    else
      chk("read", {errVal, rdVal}, {17'h00000, sh[r]});
    #1 check_pins;
  endtask

  initial
  begin
    mclk = 0;
    sys_rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 20'h00000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    rnd = 16'h9E14;
    miscompares = 0;
    n_compared = 0;
    ra[0] = 20'(`IDX_PORT_A_DATA_LOW * 4);
    ra[1] = 20'(`IDX_PORT_E_DIRECTION * 4);
    ra[2] = 20'(`IDX_PORT_E_FUNCTION_HIGH * 4);
    ra[3] = 20'(`IDX_PORT_E_FUNCTION_LOW * 4);
    wm[0] = 16'hFFFF;
    wm[1] = 16'hFFFF;
    wm[2] = 16'hF000;
    wm[3] = 16'h55FF;
    for (k = 0; k < 4; k = k + 1)
      sh[k] = 16'h0000;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (k = 0; k < 4; k = k + 1)
      acc(1'b0, k[1:0], 16'h0000, 4'h0);
    apb(1'b0, ra[3] + 20'h00004, 16'h0000, 4'h0);
    chk("unmapped", {errVal, rdVal}, {1'b1, 32'h00000000});
    $display("reset and decode test done");
    for (k = 0; k < 4; k = k + 1)
    begin
      c = k[1:0];
      acc(1'b1, 2'h1, nx(0), 4'h3);
      acc(1'b1, 2'h2, {c, c, 12'hFFF}, 4'h3);
      acc(1'b1, 2'h3, {{4{1'b1, c[0]}}, {4{c}}}, 4'h3);
      for (j = 1; j < 4; j = j + 1)
        acc(1'b0, j[1:0], 16'h0000, 4'h0);
      repeat (4)
      begin
        @(posedge mclk);
        #1 check_pins;
      end
    end
    $display("function code test done");
    repeat (60)
    begin
      k = nx(0);
      acc(1'b1, k[1:0], nx(0), k[5:2]);
      acc(1'b0, k[1:0], 16'h0000, 4'h0);
    end
    $display("random access test done");
    end_sim;
  end

  initial
  begin
    #(25 * 20000);
    miscompares = miscompares + 1;
    end_sim;
  end
endmodule // port_e_pin_function_select_bench

bind port_e_pin_function_select port_e_pin_function_select_monitor u_mon (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .pready(pready),
  .prdata(prdata),
  .pslverr(pslverr),
  .peIn(peIn),
  .peOut(peOut),
  .peOe(peOe),
  .peDataLatch(peDataLatch),
  .paDataLow(paDataLow),
  .timerCcIn(timerCcIn),
  .dmaRequestCh1(dmaRequestCh1)
);
